// ### design/ls_driver_pkg.sv
// package: register map, field layout and bundled types of the low-side driver controller
package ls_driver_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DIRECT_GATE   = 8'h00;
  localparam logic [7:0] IDX_CONFIG        = 8'h01;
  localparam logic [7:0] IDX_FACTORY_TEST  = 8'h03;
  localparam logic [7:0] IDX_OPEN_LOAD     = 8'h04;
  localparam logic [7:0] IDX_IRQ_ENABLE    = 8'h05;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'h06;
  localparam logic [7:0] IDX_SOURCE_SEL    = 8'h07;

  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_PROTECT_DISABLE = 7;
  localparam int BIT_CLAMP_SHIFT     = 6;
  localparam int BIT_IRQ_EN          = 7;
  localparam int LSB_OL_DETECT_EN    = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // gate source choice per driver
  typedef enum logic [1:0] {
    SRC_DIRECT = 2'b00,
    SRC_TIMER  = 2'b01,
    SRC_PWM    = 2'b10
  } gate_src_t;

  // analogue-side inputs per driver
  typedef struct packed {
    logic [1:0] overcurrent;
    logic [1:0] pin_near_ground;
  } analog_in_t;

  // digital controls to the analogue side
  typedef struct packed {
    logic [1:0] gate;
    logic [1:0] power_enable;
    logic [1:0] ol_detect_active;
    logic       clamp_shift;
  } analog_out_t;

endpackage

// ### design/ls_driver_ctrl.sv
// low-side driver control and protection with an AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module ls_driver_ctrl
  import ls_driver_pkg::*;
#(
  parameter int NUM_DRV = 2
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // chip mode (pins, synchronised here)
  input  wire logic              special_mode,
  input  wire logic              cpu_run_mode,
  // timer and pwm gate sources
  input  wire logic [1:0]        timer_gate,
  input  wire logic [1:0]        pwm_gate,
  // analogue side
  input  wire analog_in_t        analog_in,
  output analog_out_t            analog_out,
  // interrupt
  output logic                   driver_block_irq
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= {special_mode, cpu_run_mode, timer_gate, pwm_gate, 2'b00};
      sync2 <= sync1;
    end
  end
  logic [3:0] sync_ana1;
  logic [3:0] sync_ana2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ana1 <= 4'h0;
      sync_ana2 <= 4'h0;
    end else begin
      sync_ana1 <= analog_in;
      sync_ana2 <= sync_ana1;
    end
  end
  logic       special_s;
  logic       run_s;
  logic [1:0] timer_s;
  logic [1:0] pwm_s;
  logic [1:0] oc_live;
  logic [1:0] near_gnd;
  assign special_s = sync2[7];
  assign run_s     = sync2[6];
  assign timer_s   = sync2[5:4];
  assign pwm_s     = sync2[3:2];
  assign oc_live   = sync_ana2[3:2];
  assign near_gnd  = sync_ana2[1:0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [1:0] direct_gate_bit;
  logic [1:0] driver_power_enable;
  logic [1:0] open_load_detect_enable;
  logic       protect_disable;
  logic       clamp_shift;
  logic       overcurrent_irq_en;
  logic [1:0] overcurrent_flag;
  logic [1:0] open_load_status_bit;
  logic [3:0] source_sel;

  // ---------------------------------------------------------------
  // axi write channel
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              w_held;
  logic              do_write;
  logic [7:0]        w_idx;
  logic [7:0]        wbyte;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign w_idx    = {2'b00, aw_addr[ADDR_W-1:2]};
  assign wbyte    = w_data[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) aw_held <= 1'b0;
      s_axi_awready <= !aw_held && !s_axi_awready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_lane0      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) w_held <= 1'b0;
      s_axi_wready <= !w_held && !s_axi_wready;
    end
  end

  logic known_w;
  always_comb begin
    case (w_idx)
      IDX_DIRECT_GATE, IDX_CONFIG, IDX_FACTORY_TEST, IDX_OPEN_LOAD,
      IDX_IRQ_ENABLE, IDX_IRQ_FLAGS, IDX_SOURCE_SEL: known_w = 1'b1;
      default: known_w = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_w ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = do_write && w_lane0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direct_gate_bit <= 2'b00;
      source_sel      <= 4'h0;
    end else begin
      if (wr_en && w_idx == IDX_DIRECT_GATE) direct_gate_bit <= wbyte[1:0];
      if (wr_en && w_idx == IDX_SOURCE_SEL) source_sel <= wbyte[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      driver_power_enable     <= 2'b00;
      open_load_detect_enable <= 2'b00;
    end else if (wr_en && w_idx == IDX_CONFIG) begin
      driver_power_enable     <= wbyte[1:0];
      open_load_detect_enable <= wbyte[LSB_OL_DETECT_EN +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protect_disable <= 1'b0;
      clamp_shift     <= 1'b0;
    end else if (wr_en && w_idx == IDX_FACTORY_TEST && special_s) begin
      protect_disable <= wbyte[BIT_PROTECT_DISABLE];
      clamp_shift     <= wbyte[BIT_CLAMP_SHIFT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) overcurrent_irq_en <= 1'b0;
    else if (wr_en && w_idx == IDX_IRQ_ENABLE) overcurrent_irq_en <= wbyte[BIT_IRQ_EN];
  end

  // ---------------------------------------------------------------
  // per-driver gate and protection
  // ---------------------------------------------------------------
  logic [1:0] sel_src;
  logic [1:0] next_gate;
  logic [1:0] ol_active;
  logic [1:0] oc_event;
  logic [1:0] flag_clear;
  assign flag_clear = (wr_en && w_idx == IDX_IRQ_FLAGS) ? wbyte[1:0] : 2'b00;

  genvar g;
  generate
    for (g = 0; g < NUM_DRV; g++) begin : gen_drv
      always_comb begin
        case (gate_src_t'(source_sel[2*g +: 2]))
          SRC_DIRECT: sel_src[g] = direct_gate_bit[g];
          SRC_TIMER:  sel_src[g] = timer_s[g];
          SRC_PWM:    sel_src[g] = pwm_s[g];
          default:    sel_src[g] = direct_gate_bit[g];
        endcase
      end
      assign oc_event[g] = oc_live[g] && driver_power_enable[g];
      assign next_gate[g] = sel_src[g] && driver_power_enable[g] &&
                            (!overcurrent_flag[g] || protect_disable);
      assign ol_active[g] = open_load_detect_enable[g] && driver_power_enable[g] &&
                            !sel_src[g];

      always_ff @(posedge aclk) begin
        if (!aresetn) overcurrent_flag[g] <= 1'b0;
        else if (oc_event[g]) overcurrent_flag[g] <= 1'b1;
        else if (flag_clear[g]) overcurrent_flag[g] <= 1'b0;
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) open_load_status_bit[g] <= 1'b0;
        else if (ol_active[g]) open_load_status_bit[g] <= near_gnd[g];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs to analogue side and irq
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_out <= '0;
    end else begin
      analog_out.gate             <= next_gate;
      analog_out.power_enable     <= driver_power_enable;
      analog_out.ol_detect_active <= ol_active;
      analog_out.clamp_shift      <= clamp_shift;
    end
  end

  // irq request in run mode only
  always_ff @(posedge aclk) begin
    if (!aresetn) driver_block_irq <= 1'b0;
    else driver_block_irq <= overcurrent_irq_en && (|overcurrent_flag) && run_s;
  end

  // ---------------------------------------------------------------
  // axi read channel
  // ---------------------------------------------------------------
  logic [7:0] r_idx;
  logic [7:0] rbyte;
  logic       r_known;
  assign r_idx = {2'b00, s_axi_araddr[ADDR_W-1:2]};
  always_comb begin
    r_known = 1'b1;
    case (r_idx)
      IDX_DIRECT_GATE:  rbyte = {6'h00, direct_gate_bit};
      IDX_CONFIG:       rbyte = {4'h0, open_load_detect_enable, driver_power_enable};
      IDX_FACTORY_TEST: rbyte = {protect_disable, clamp_shift, 4'h0, oc_live};
      IDX_OPEN_LOAD:    rbyte = {6'h00, open_load_status_bit};
      IDX_IRQ_ENABLE:   rbyte = {overcurrent_irq_en, 7'h00};
      IDX_IRQ_FLAGS:    rbyte = {6'h00, overcurrent_flag};
      IDX_SOURCE_SEL:   rbyte = {4'h0, source_sel};
      default: begin
        rbyte   = RST_REG8;
        r_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AXI_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rbyte};
      s_axi_rresp   <= r_known ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_test_write_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && w_idx == IDX_FACTORY_TEST && !special_s) |=>
      $stable(protect_disable) && $stable(clamp_shift))
    else $error("test bits changed outside special mode");

  a_flag_gate_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (overcurrent_flag[0] && !protect_disable) |=> !analog_out.gate[0])
    else $error("gate 0 on while flag set");

  a_protect_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (protect_disable && sel_src[0] && driver_power_enable[0]) |=> analog_out.gate[0])
    else $error("gate 0 off although protection disabled");

  a_flag_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (oc_event[0] && flag_clear[0]) |=> overcurrent_flag[0])
    else $error("flag clear beat a new event");

  a_flag_clear_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (!oc_event[1] && flag_clear[1]) |=> !overcurrent_flag[1])
    else $error("write one did not clear flag 1");

  a_oc_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    (!driver_power_enable[0] && !overcurrent_flag[0] && !flag_clear[0]) |=>
      !overcurrent_flag[0] || $past(oc_live[0]) && $past(driver_power_enable[0]))
    else $error("flag 0 set while driver disabled");

  a_irq_request: assert property (@(posedge aclk) disable iff (!aresetn)
    (overcurrent_irq_en && |overcurrent_flag && run_s) |=> driver_block_irq)
    else $error("irq missing with enabled flag");

  a_irq_no_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_s |=> !driver_block_irq)
    else $error("irq raised outside run mode");

  a_ol_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !ol_active[0] |=> $stable(open_load_status_bit[0]))
    else $error("open-load bit moved while unqualified");

  a_ol_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (ol_active[1] && near_gnd[1]) |=> open_load_status_bit[1])
    else $error("open load not flagged");

  a_ol_src_on: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_src[0] |-> !ol_active[0])
    else $error("detection active with source on");

endmodule // ls_driver_ctrl

// ### tb/load_model.sv
// behavioural model of the inductive loads hanging on both driver pins
module load_model
  import ls_driver_pkg::*;
(
  // clock
  input  wire logic        aclk,
  // driver side
  input  wire analog_out_t drv_out,
  output analog_in_t       sense,
  // fault injection
  input  wire logic [1:0]  load_open,
  input  wire logic [1:0]  load_short
);
  timeunit 1ns;
  timeprecision 1ps;

  initial sense = '0;

  // ---------------------------------------------------------------
  // load behaviour
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    sense.overcurrent <= drv_out.gate & drv_out.power_enable & load_short;
    // pin low when conducting or load missing
    sense.pin_near_ground <= drv_out.gate | load_open;
  end
endmodule // load_model

// ### tb/tb.sv
// self-checking bench of the low-side driver controller
module tb
  import ls_driver_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0]       s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = '0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, last_resp;
  logic [31:0]       s_axi_rdata, last_rdata;
  logic              special_mode = 1'b0, cpu_run_mode = 1'b1;
  logic [1:0]        timer_gate = '0, pwm_gate = '0, load_open = '0, load_short = '0;
  logic [1:0]        exp_gate;
  analog_in_t        ain;
  analog_out_t       aout;
  logic              driver_block_irq;
  int                n_mismatch = 0;
  int                checks_done = 0;

  always #5 aclk = ~aclk;

  ls_driver_ctrl ls_driver_ctrl_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .special_mode(special_mode),
    .cpu_run_mode(cpu_run_mode), .timer_gate(timer_gate), .pwm_gate(pwm_gate),
    .analog_in(ain), .analog_out(aout), .driver_block_irq(driver_block_irq)
  );

  load_model load_model_i (
    .aclk(aclk), .drv_out(aout), .sense(ain), .load_open(load_open), .load_short(load_short)
  );

  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= idx << 2;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok) && n < 50);
    while (!s_axi_bvalid && n < 100) begin
      @(posedge aclk);
      n++;
    end
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) n_mismatch++;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= idx << 2;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    last_rdata = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) n_mismatch++;
    chk(last_rdata, exp);
  endtask

  // settle through synchronisers, then look at the gate pins
  task automatic gate_chk(input logic [1:0] exp);
    repeat (8) @(posedge aclk);
    chk({30'h0, aout.gate}, {30'h0, exp});
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #500us;
    n_mismatch++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_IRQ_FLAGS, 32'h0);
    rd(IDX_OPEN_LOAD, 32'h0);
    rd(IDX_FACTORY_TEST, 32'h0);
    rd(8'h02, 32'h0);
    chk({30'h0, last_resp}, {30'h0, AXI_SLVERR});
    wr(8'h02, 32'h0000_00ff);
    chk({30'h0, last_resp}, {30'h0, AXI_SLVERR});
    // source selection for every code
    wr(IDX_CONFIG, 32'h3);
    timer_gate <= 2'b10;
    pwm_gate <= 2'b01;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_SOURCE_SEL, 32'(s | (s << 2)));
      exp_gate = (s == 1) ? 2'b10 : (s == 2) ? 2'b01 : 2'b00;
      gate_chk(exp_gate);
    end
    wr(IDX_SOURCE_SEL, 32'h4);
    wr(IDX_CONFIG, 32'h1);
    gate_chk(2'b00);
    // overcurrent latch, interrupt and clear
    wr(IDX_SOURCE_SEL, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h80);
    load_short <= 2'b01;
    wr(IDX_DIRECT_GATE, 32'h1);
    gate_chk(2'b00);
    rd(IDX_IRQ_FLAGS, 32'h1);
    chk({31'h0, driver_block_irq}, 32'h1);
    wr(IDX_IRQ_FLAGS, 32'h0);
    rd(IDX_IRQ_FLAGS, 32'h1);
    cpu_run_mode <= 1'b0;
    gate_chk(2'b00);
    chk({31'h0, driver_block_irq}, 32'h0);
    cpu_run_mode <= 1'b1;
    rd(IDX_IRQ_FLAGS, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h0);
    gate_chk(2'b00);
    chk({31'h0, driver_block_irq}, 32'h0);
    load_short <= 2'b00;
    wr(IDX_IRQ_FLAGS, 32'h3);
    gate_chk(2'b01);
    rd(IDX_IRQ_FLAGS, 32'h0);
    // factory test register
    wr(IDX_FACTORY_TEST, 32'hc0);
    chk({30'h0, last_resp}, {30'h0, AXI_OKAY});
    rd(IDX_FACTORY_TEST, 32'h0);
    special_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(IDX_FACTORY_TEST, 32'hc0);
    rd(IDX_FACTORY_TEST, 32'hc0);
    chk({31'h0, aout.clamp_shift}, 32'h1);
    load_short <= 2'b01;
    gate_chk(2'b01);
    rd(IDX_FACTORY_TEST, 32'hc1);
    // clear while the event persists: the event keeps the flag
    wr(IDX_IRQ_FLAGS, 32'h1);
    rd(IDX_IRQ_FLAGS, 32'h1);
    load_short <= 2'b00;
    wr(IDX_FACTORY_TEST, 32'h0);
    wr(IDX_IRQ_FLAGS, 32'h1);
    special_mode <= 1'b0;
    // open-load qualification
    wr(IDX_DIRECT_GATE, 32'h2);
    wr(IDX_CONFIG, 32'h0c);
    load_open <= 2'b10;
    gate_chk(2'b00);
    rd(IDX_OPEN_LOAD, 32'h0);
    wr(IDX_CONFIG, 32'h0f);
    gate_chk(2'b10);
    chk({30'h0, aout.power_enable}, 32'h3);
    chk({30'h0, aout.ol_detect_active}, 32'h1);
    rd(IDX_OPEN_LOAD, 32'h0);
    wr(IDX_DIRECT_GATE, 32'h0);
    gate_chk(2'b00);
    rd(IDX_OPEN_LOAD, 32'h2);
    load_open <= 2'b00;
    gate_chk(2'b00);
    rd(IDX_OPEN_LOAD, 32'h0);
    finish_test();
  end
endmodule // tb
